// file: hw/hdt_host_ctrl.sv
// DDR4 host-side sequencer: reset, calibration, self refresh and power-down timing.
// Assumes the user side runs on mclk; dqs_i arrives from the pad asynchronously.
`timescale 1ns/100ps
module hdt_host_ctrl #(
	parameter int CK_DIV        = 2,
	parameter int T_RFC_NS      = 260,
	parameter int T_RFC4_NS     = 160,
	parameter int READ_LAT      = 17,
	parameter int WRITE_LAT     = 12,
	parameter int BURST_LEN     = 8,
	parameter int PARITY_LAT    = 4,
	parameter int RESET_HOLD_CK = 16,
	parameter int ARM_HOLD_CK   = 16
) (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       par_en,
	input  wire logic                       req_valid,
	input  hdt_pkg::hdt_op_t                req_op,
	input  wire logic [hdt_pkg::ADDR_W-1:0] req_addr,
	output logic                            req_ready,
	output hdt_pkg::hdt_pins_t              pins,
	output logic                            ck,
	input  wire logic                       dqs_i,
	output logic                            dqs_o,
	output logic                            dqs_oe_n,
	output logic                            rd_gate,
	output logic                            rd_strobe_seen,
	output logic                            init_done
);
	import hdt_pkg::*;

	// ==================================================================
	// Derived counts
	localparam int CK_NS = CLK_PERIOD_NS * CK_DIV;
	localparam logic [CNT_W-1:0] TXPR      =
		CNT_W'(max2(T_XPR_MIN_CK, ck_ceil(T_RFC_NS + T_RFC_PAD_NS, CK_NS)));
	localparam logic [CNT_W-1:0] TXS       = CNT_W'(ck_ceil(T_RFC_NS + T_RFC_PAD_NS, CK_NS));
	localparam logic [CNT_W-1:0] TXS_FAST  = CNT_W'(ck_ceil(T_RFC4_NS + T_RFC_PAD_NS, CK_NS));
	localparam logic [CNT_W-1:0] TXS_ABORT = TXS_FAST;
	localparam logic [CNT_W-1:0] TCKE      =
		CNT_W'(max2(T_CKE_MIN_CK, ck_ceil(T_CKE_NS, CK_NS)));
	localparam logic [CNT_W-1:0] TCKESR    = TCKE + CNT_W'(T_CKESR_PAD_CK);
	localparam logic [CNT_W-1:0] TCKSRE    =
		CNT_W'(max2(T_CKSRE_MIN_CK, ck_ceil(T_CKSRE_NS, CK_NS)));
	localparam logic [CNT_W-1:0] TCKSRX    =
		CNT_W'(max2(T_CKSRX_MIN_CK, ck_ceil(T_CKSRX_NS, CK_NS)));
	localparam logic [CNT_W-1:0] TXP       = CNT_W'(max2(T_XP_MIN_CK, ck_ceil(T_XP_NS, CK_NS)));
	localparam logic [CNT_W-1:0] TDLLK     = CNT_W'(T_DLLK_CK);
	localparam logic [CNT_W-1:0] INIT_CALIB_WAIT   = CNT_W'(T_ZQINIT_CK);
	localparam logic [CNT_W-1:0] FULL_CALIB_WAIT   = CNT_W'(T_ZQOPER_CK);
	localparam logic [CNT_W-1:0] TZQCS     = CNT_W'(T_ZQCS_CK);
	localparam logic [CNT_W-1:0] RST_HOLD  = CNT_W'(RESET_HOLD_CK);
	localparam logic [CNT_W-1:0] ARM_HOLD  = CNT_W'(ARM_HOLD_CK);
	localparam logic [CNT_W-1:0] PAR_LAT_CK = CNT_W'(PARITY_LAT);
	localparam logic [7:0] RD_ON   = 8'(READ_LAT - 1);
	localparam logic [7:0] RD_OFF  = 8'(READ_LAT + BURST_LEN / 2);
	localparam logic [7:0] WR_ON   = 8'(WRITE_LAT - WR_PRE_CK);
	localparam logic [7:0] WR_BST  = 8'(WRITE_LAT);
	localparam logic [7:0] WR_END  = 8'(WRITE_LAT + BURST_LEN / 2);
	localparam logic [7:0] DIV_TOP = 8'(CK_DIV - 1);
	localparam logic [7:0] DIV_HI  = 8'(CK_DIV / 2);

	typedef enum {S_RST, S_ARM, S_INIT_ZQ, S_RUN, S_LOW, S_WAKE} hdt_state_t;

	hdt_state_t       state_reg;
	hdt_pins_t        pins_reg;
	logic [7:0]       div_reg;
	logic             ck_reg;
	logic             ck_en_reg;
	logic             tick;
	logic [CNT_W-1:0] gap_reg;
	logic [CNT_W-1:0] cke_gap_reg;
	hdt_op_t          last_op_reg;
	logic             zq_init_reg;
	logic             lp_sr_reg;
	logic             abort_reg;
	logic             after_srx_reg;
	logic             after_rst_reg;
	logic [7:0]       rd_cnt_reg;
	logic             rd_act_reg;
	logic [7:0]       wr_cnt_reg;
	logic             wr_act_reg;
	logic             wr_burst_reg;
	logic             dqs_o_reg;
	logic             dqs_oe_n_reg;
	logic             rd_gate_reg;
	logic             seen_reg;
	logic             dqs_s1_reg;
	logic             dqs_s2_reg;
	logic             dqs_s3_reg;
	logic             state_ok;
	logic             issue;
	logic             auto_zq;
	logic             cke_rise;
	logic             cmd_fire;
	hdt_op_t          fire_op;
	logic             burst_busy;
	logic [CNT_W-1:0] tckesr_eff;
	logic [CNT_W-1:0] tcksre_eff;
	logic [CH_NUM-1:0]            busy;
	logic [CH_NUM-1:0]            ld;
	logic [CH_NUM-1:0][CNT_W-1:0] val;

	assign ck             = ck_reg;
	assign pins           = pins_reg;
	assign dqs_o          = dqs_o_reg;
	assign dqs_oe_n       = dqs_oe_n_reg;
	assign rd_gate        = rd_gate_reg;
	assign rd_strobe_seen = seen_reg;
	assign init_done      = (state_reg == S_RUN) || (state_reg == S_LOW) || (state_reg == S_WAKE);
	assign tckesr_eff     = TCKESR + (par_en ? PAR_LAT_CK : '0);
	assign tcksre_eff     = TCKSRE + (par_en ? PAR_LAT_CK : '0);
	assign burst_busy     = rd_act_reg || wr_act_reg;

	// ==================================================================
	// CK divider; tick marks the mclk cycle before each CK rising edge
	assign tick = (div_reg == DIV_TOP);

	always_ff @(posedge mclk) begin
		if (rst) begin
			div_reg <= '0;
			ck_reg  <= 1'b0;
		end else begin
			div_reg <= tick ? '0 : div_reg + 8'd1;
			ck_reg  <= ck_en_reg && (tick || (div_reg < DIV_HI - 8'd1));
		end
	end

	// ==================================================================
	// Guard timers
	generate
		for (genvar i = 0; i < CH_NUM; i++) begin : g_tmr
			hdt_wait_timer #(.W(CNT_W)) u_tmr (
				.mclk  (mclk),
				.rst   (rst),
				.tick  (tick),
				.load  (ld[i]),
				.value (val[i]),
				.busy  (busy[i])
			);
		end
	endgenerate

	// ==================================================================
	// Admission
	always_comb begin
		state_ok = 1'b0;
		unique case (state_reg)
			S_RUN: begin
				state_ok = !is_wake_op(req_op) && !busy[CH_ALL]
					&& (is_fast_op(req_op) || !busy[CH_NODLL])
					&& (!is_dll_op(req_op) || !busy[CH_DLL])
					&& !(burst_busy && (is_dll_op(req_op)
						|| req_op == OP_SRE || req_op == OP_PDE));
			end
			S_LOW: begin
				state_ok = !busy[CH_CKE] && (lp_sr_reg ? (req_op == OP_SRX
					|| req_op == OP_SRX_ABORT) : (req_op == OP_PDX));
			end
			S_RST, S_ARM, S_INIT_ZQ, S_WAKE: state_ok = 1'b0;
		endcase
	end

	assign req_ready = tick && state_ok;
	assign issue     = req_valid && req_ready;
	assign auto_zq   = tick && (state_reg == S_INIT_ZQ) && !busy[CH_ALL];
	assign cke_rise  = tick && (((state_reg == S_WAKE) && !busy[CH_CLK])
		|| ((state_reg == S_ARM) && (gap_reg >= RST_HOLD + ARM_HOLD)));
	assign fire_op   = auto_zq ? OP_ZQCL : req_op;
	assign cmd_fire  = auto_zq || (issue && !is_wake_op(req_op));

	always_comb begin
		ld  = '0;
		val = '0;
		if (auto_zq) begin
			ld[CH_ALL]  = 1'b1;
			val[CH_ALL] = INIT_CALIB_WAIT;
		end
		if (issue) begin
			unique case (req_op)
				OP_ZQCL: begin
					ld[CH_ALL]  = 1'b1;
					val[CH_ALL] = FULL_CALIB_WAIT;
				end
				OP_ZQCS: begin
					ld[CH_ALL]  = 1'b1;
					val[CH_ALL] = TZQCS;
				end
				OP_SRE, OP_PDE: begin
					ld[CH_CKE]  = 1'b1;
					val[CH_CKE] = (req_op == OP_SRE) ? tckesr_eff : TCKE;
					ld[CH_CLK]  = 1'b1;
					val[CH_CLK] = tcksre_eff;
				end
				OP_SRX, OP_SRX_ABORT, OP_PDX: begin
					ld[CH_CLK]  = 1'b1;
					val[CH_CLK] = TCKSRX;
				end
				default: ;
			endcase
		end
		if (cke_rise) begin
			ld[CH_ALL] = 1'b1;
			if (state_reg == S_ARM) begin
				val[CH_ALL] = TXPR;
			end else if (lp_sr_reg) begin
				val[CH_ALL]   = TXS_FAST;
				ld[CH_NODLL]  = 1'b1;
				val[CH_NODLL] = abort_reg ? TXS_ABORT : TXS;
				ld[CH_DLL]    = 1'b1;
				val[CH_DLL]   = TDLLK;
			end else begin
				val[CH_ALL] = TXP;
			end
		end
	end

	// ==================================================================
	// Sequencer and pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= S_RST;
			pins_reg  <= '{reset_n: 1'b0, cke: 1'b0, op: OP_NOP, addr: '0};
			ck_en_reg <= 1'b1;
			lp_sr_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else if (tick) begin
			pins_reg.op   <= OP_NOP;
			pins_reg.addr <= req_addr;
			unique case (state_reg)
				S_RST: if (gap_reg >= RST_HOLD) begin
					pins_reg.reset_n <= 1'b1;
					state_reg        <= S_ARM;
				end
				S_ARM: if (cke_rise) begin
					pins_reg.cke <= 1'b1;
					state_reg    <= S_INIT_ZQ;
				end
				S_INIT_ZQ: if (auto_zq) begin
					pins_reg.op <= OP_ZQCL;
					state_reg   <= S_RUN;
				end
				S_RUN: if (issue) begin
					pins_reg.op <= (req_op == OP_SRE) ? OP_REF
						: (req_op == OP_PDE) ? OP_NOP : req_op;
					if (req_op == OP_SRE || req_op == OP_PDE) begin
						pins_reg.cke <= 1'b0;
						lp_sr_reg    <= (req_op == OP_SRE);
						state_reg    <= S_LOW;
					end
				end
				S_LOW: begin
					// Clock may only stop in self refresh, once its valid window has run
					if (lp_sr_reg && !busy[CH_CLK] && !issue) begin
						ck_en_reg <= 1'b0;
					end
					if (issue) begin
						ck_en_reg <= 1'b1;
						abort_reg <= (req_op == OP_SRX_ABORT);
						state_reg <= S_WAKE;
					end
				end
				S_WAKE: if (cke_rise) begin
					pins_reg.cke <= 1'b1;
					state_reg    <= S_RUN;
				end
			endcase
		end
	end

	// ==================================================================
	// Gap tracking for command spacing
	always_ff @(posedge mclk) begin
		if (rst) begin
			gap_reg       <= '0;
			cke_gap_reg   <= '0;
			last_op_reg   <= OP_NOP;
			zq_init_reg   <= 1'b0;
			after_srx_reg <= 1'b0;
			after_rst_reg <= 1'b0;
		end else if (tick) begin
			if (cmd_fire) begin
				gap_reg     <= CNT_W'(1);
				last_op_reg <= fire_op;
				zq_init_reg <= auto_zq;
			end else if (gap_reg != '1) begin
				gap_reg <= gap_reg + CNT_W'(1);
			end
			if (cke_rise || (issue && (req_op == OP_SRE || req_op == OP_PDE))) begin
				cke_gap_reg <= CNT_W'(1);
			end else if (cke_gap_reg != '1) begin
				cke_gap_reg <= cke_gap_reg + CNT_W'(1);
			end
			if (cke_rise) begin
				after_rst_reg <= (state_reg == S_ARM);
				after_srx_reg <= (state_reg == S_WAKE) && lp_sr_reg;
			end
		end
	end

	// ==================================================================
	// Read strobe window and write strobe drive
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_cnt_reg <= '0;
			rd_act_reg <= 1'b0;
			wr_cnt_reg <= '0;
			wr_act_reg <= 1'b0;
		end else if (tick) begin
			if (issue && req_op == OP_RD) begin
				rd_cnt_reg <= 8'd0;
				rd_act_reg <= 1'b1;
			end else if (rd_act_reg) begin
				rd_act_reg <= (rd_cnt_reg != RD_OFF);
				rd_cnt_reg <= rd_cnt_reg + 8'd1;
			end
			if (issue && req_op == OP_WR) begin
				wr_cnt_reg <= 8'd0;
				wr_act_reg <= 1'b1;
			end else if (wr_act_reg) begin
				wr_act_reg <= (wr_cnt_reg != WR_END);
				wr_cnt_reg <= wr_cnt_reg + 8'd1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_gate_reg  <= 1'b0;
			wr_burst_reg <= 1'b0;
			dqs_oe_n_reg <= 1'b1;
			dqs_o_reg    <= 1'b0;
		end else begin
			// Counts CK edges from the command edge; window spans drive to release
			rd_gate_reg  <= rd_act_reg && rd_cnt_reg >= RD_ON && rd_cnt_reg < RD_OFF;
			wr_burst_reg <= wr_act_reg && wr_cnt_reg >= WR_BST && wr_cnt_reg < WR_END;
			// Postamble is one and a half CK low, comfortably above the minimum
			dqs_oe_n_reg <= !(wr_act_reg && wr_cnt_reg >= WR_ON && wr_cnt_reg <= WR_END);
			dqs_o_reg    <= wr_act_reg && wr_cnt_reg >= WR_BST && wr_cnt_reg < WR_END
				&& (div_reg < DIV_HI);
		end
	end

	// Strobe presence: first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (rst) begin
			dqs_s1_reg <= 1'b1;
			dqs_s2_reg <= 1'b1;
			dqs_s3_reg <= 1'b1;
			seen_reg   <= 1'b0;
		end else begin
			dqs_s1_reg <= dqs_i;
			dqs_s2_reg <= dqs_s1_reg;
			dqs_s3_reg <= dqs_s2_reg;
			// Needs a rising edge: a released strobe idles high and proves nothing
			if (rd_gate_reg && dqs_s2_reg && !dqs_s3_reg) begin
				seen_reg <= 1'b1;
			end else if (issue && req_op == OP_RD) begin
				seen_reg <= 1'b0;
			end
		end
	end

	// ==================================================================
	// Checks
	sequence s_burst_end;
		$fell(wr_burst_reg);
	endsequence
	sequence s_post_hold;
		!dqs_oe_n_reg [*2];
	endsequence

	a_zq_init_wait: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && last_op_reg == OP_ZQCL && zq_init_reg |-> gap_reg >= INIT_CALIB_WAIT)
		else $error("command too soon after initial calibration");
	a_zq_full_wait: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && last_op_reg == OP_ZQCL && !zq_init_reg |-> gap_reg >= FULL_CALIB_WAIT)
		else $error("command too soon after full calibration");
	a_zq_short_wait: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && last_op_reg == OP_ZQCS |-> gap_reg >= TZQCS)
		else $error("command too soon after short calibration");
	a_reset_exit: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && after_rst_reg |-> cke_gap_reg >= TXPR)
		else $error("command too soon after reset exit");
	a_srx_nodll: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && after_srx_reg && !abort_reg && !is_fast_op(fire_op)
		|-> cke_gap_reg >= TXS)
		else $error("command too soon after self refresh exit");
	a_abort_nodll: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && after_srx_reg && abort_reg |-> cke_gap_reg >= TXS_ABORT)
		else $error("command too soon after aborted self refresh");
	a_fast_cmd: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && after_srx_reg && is_fast_op(fire_op) |-> cke_gap_reg >= TXS_FAST)
		else $error("calibration or mode write too soon after exit");
	a_dll_lock: assert property (@(posedge mclk) disable iff (rst)
		cmd_fire && after_srx_reg && is_dll_op(fire_op) |-> cke_gap_reg >= TDLLK)
		else $error("read or write before DLL lock");
	a_cke_low_width: assert property (@(posedge mclk) disable iff (rst)
		$rose(pins_reg.cke) && lp_sr_reg |-> $past(cke_gap_reg) >= $past(tckesr_eff))
		else $error("CKE low too short in self refresh");
	a_clk_valid: assert property (@(posedge mclk) disable iff (rst)
		$fell(ck_en_reg) |-> !pins_reg.cke && $past(cke_gap_reg) >= $past(tcksre_eff))
		else $error("clock stopped too early after entry");
	a_wr_postamble: assert property (@(posedge mclk) disable iff (rst)
		s_burst_end |-> s_post_hold)
		else $error("write postamble too short");
endmodule

// file: hw/hdt_pkg.sv
// Constants, types and helpers for the DDR4 host-side timing sequencer.
// Assumes a single 125 MHz system clock; all DRAM waits are counted in CK periods.
package hdt_pkg;

	// ==================================================================
	// Timing figures, CK periods or ns as named
	localparam int CLK_PERIOD_NS   = 8;
	localparam int CNT_W           = 12;
	localparam int T_ZQINIT_CK     = 1024;
	localparam int T_ZQOPER_CK     = 512;
	localparam int T_ZQCS_CK       = 128;
	localparam int T_XPR_MIN_CK    = 5;
	localparam int T_RFC_PAD_NS    = 10;
	localparam int T_CKSRE_MIN_CK  = 5;
	localparam int T_CKSRE_NS      = 10;
	localparam int T_CKSRX_MIN_CK  = 5;
	localparam int T_CKSRX_NS      = 10;
	localparam int T_CKE_MIN_CK    = 3;
	localparam int T_CKE_NS        = 5;
	localparam int T_CKESR_PAD_CK  = 1;
	localparam int T_XP_MIN_CK     = 4;
	localparam int T_XP_NS         = 6;
	localparam int T_DLLK_CK       = 768;
	localparam int WR_PRE_CK       = 1;
	localparam int ADDR_W          = 17;

	// ==================================================================
	// Timer channels
	localparam int CH_ALL   = 0;
	localparam int CH_NODLL = 1;
	localparam int CH_DLL   = 2;
	localparam int CH_CKE   = 3;
	localparam int CH_CLK   = 4;
	localparam int CH_NUM   = 5;

	// ==================================================================
	// Commands and pins
	typedef enum logic [3:0] {
		OP_NOP, OP_MRS, OP_REF, OP_PRE, OP_ACT, OP_RD, OP_WR, OP_ZQCL, OP_ZQCS,
		OP_SRE, OP_SRX, OP_SRX_ABORT, OP_PDE, OP_PDX
	} hdt_op_t;

	typedef struct packed {
		logic              reset_n;
		logic              cke;
		hdt_op_t           op;
		logic [ADDR_W-1:0] addr;
	} hdt_pins_t;

	// ==================================================================
	// Helpers
	function automatic int ck_ceil(int ns, int ck_ns);
		return (ns + ck_ns - 1) / ck_ns;
	endfunction

	function automatic int max2(int a, int b);
		return (a > b) ? a : b;
	endfunction

	function automatic logic is_dll_op(hdt_op_t op);
		return (op == OP_RD) || (op == OP_WR);
	endfunction

	function automatic logic is_fast_op(hdt_op_t op);
		return (op == OP_ZQCL) || (op == OP_ZQCS) || (op == OP_MRS);
	endfunction

	function automatic logic is_wake_op(hdt_op_t op);
		return (op == OP_SRX) || (op == OP_SRX_ABORT) || (op == OP_PDX);
	endfunction

endpackage

// file: hw/hdt_wait_timer.sv
// Down-counting guard timer in CK periods.
// Assumes tick is a one-cycle pulse once per CK period.
`timescale 1ns/100ps
module hdt_wait_timer #(
	parameter int W = 12
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              busy
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] val_m1;

	// Busy clears value-1 ticks after the loading tick, so it is low again at the tick value ticks after
	assign val_m1 = (value == '0) ? '0 : value - W'(1);
	assign busy   = (cnt_reg != '0);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (load && tick) begin
			// A shorter load never cuts an earlier, longer wait
			cnt_reg <= (val_m1 > cnt_reg) ? val_m1 : cnt_reg;
		end else if (tick && busy) begin
			cnt_reg <= cnt_reg - W'(1);
		end
	end
endmodule

// file: verification/hdt_dram_model.sv
// Behavioural DDR4 device: read strobe drive window and calibration hold check.
// Assumes pins stand one CK period and change near a CK edge.
`timescale 1ns/100ps
module hdt_dram_model #(
	parameter int READ_LAT  = 17,
	parameter int BURST_LEN = 8
) (
	input  wire logic          ck,
	input  hdt_pkg::hdt_pins_t pins,
	output logic               dqs,
	output int                 viol
);
	import hdt_pkg::*;
	int   cnt  = 1000;
	int   gap  = 0;
	int   need = 0;
	logic drv  = 1'b0;
	logic bst  = 1'b0;
	initial viol = 0;

	// ==================================================================
	// Command sampling, 2 ns past the falling edge, clear of update edges
	always @(negedge ck) begin
		#2;
		cnt = (pins.op == OP_RD) ? 0 : ((cnt < 1000) ? cnt + 1 : cnt);
		if (pins.op != OP_NOP) begin
			if (gap < need) viol = viol + 1;
			need = (pins.op == OP_ZQCL) ? T_ZQOPER_CK : ((pins.op == OP_ZQCS) ? T_ZQCS_CK : 0);
			gap = 1;
		end else begin
			gap = gap + 1;
		end
	end

	// ==================================================================
	// Read strobe: preamble low, burst follows CK
	always @(posedge ck) begin
		drv <= (cnt >= READ_LAT - 2) && (cnt <= READ_LAT + BURST_LEN / 2 - 2);
		bst <= (cnt >= READ_LAT - 1);
	end

	// Released line shows the inverse of its last driven low level
	assign dqs = drv ? (bst & ck) : 1'b1;
endmodule

// file: verification/tb_hdt_host_ctrl.sv
// Self-checking bench for the DDR4 host timing sequencer.
// Assumes the device model answers reads; command gaps are measured in CK periods, strobe windows in mclk cycles.
`timescale 1ns/100ps
module tb_hdt_host_ctrl;
	import hdt_pkg::*;
	// ==================================================================
	// Figures
	localparam int CKD   = 2;
	localparam int RFC   = 260;
	localparam int RFC4  = 160;
	localparam int CKNS  = CLK_PERIOD_NS * CKD;
	localparam int TXS   = (RFC + T_RFC_PAD_NS + CKNS - 1) / CKNS;
	localparam int TXS4  = (RFC4 + T_RFC_PAD_NS + CKNS - 1) / CKNS;
	localparam int TXPR  = (TXS > T_XPR_MIN_CK) ? TXS : T_XPR_MIN_CK;
	localparam int TCKSR = T_CKE_MIN_CK + T_CKESR_PAD_CK;
	localparam int PLAT  = 4;
	localparam int RLAT  = 17;
	localparam int WL    = 12;
	localparam int BLEN  = 8;
	localparam int LIMIT = 12000;
	logic              mclk      = 1'b0;
	logic              rst       = 1'b1;
	logic              par_en    = 1'b0;
	logic              req_valid = 1'b0;
	hdt_op_t           req_op    = OP_NOP;
	logic [ADDR_W-1:0] req_addr  = '0;
	logic              req_ready, ck, dqs_o, dqs_oe_n, rd_gate, rd_strobe_seen, init_done;
	logic              dqs_dev, dqs_i;
	hdt_pins_t         pins;
	int                viol;
	int                num_errors  = 0;
	int                checks_done = 0;
	int                cyc         = 0;
	int                t0, t1, t2, first, len;

	hdt_host_ctrl #(.CK_DIV(CKD), .T_RFC_NS(RFC), .T_RFC4_NS(RFC4), .READ_LAT(RLAT),
		.WRITE_LAT(WL), .BURST_LEN(BLEN), .PARITY_LAT(PLAT), .RESET_HOLD_CK(2),
		.ARM_HOLD_CK(2)) hdt_host_ctrl_inst (.mclk(mclk), .rst(rst), .par_en(par_en),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_ready(req_ready),
		.pins(pins), .ck(ck), .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
		.rd_gate(rd_gate), .rd_strobe_seen(rd_strobe_seen), .init_done(init_done));
	hdt_dram_model #(.READ_LAT(RLAT), .BURST_LEN(BLEN)) hdt_dram_model_inst (.ck(ck),
		.pins(pins), .dqs(dqs_dev), .viol(viol));
	assign dqs_i = dqs_oe_n ? dqs_dev : dqs_o;

	initial begin
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end

	// ==================================================================
	// Shared tasks
	task automatic check_cnt(input string what, input int got, input int lo, input int hi);
		checks_done = checks_done + 1;
		if (got < lo || got > hi) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t %s got 0x%0h want 0x%0h to 0x%0h", $time, what, got, lo, hi);
		end
	endtask

	task automatic check_val(input string what, input logic [ADDR_W-1:0] got,
		input logic [ADDR_W-1:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t %s got 0x%0h want 0x%0h", $time, what, got, exp);
		end
	endtask

	// Holds the request until taken, drops it just after the taking edge, then waits one edge more
	task automatic issue(input hdt_op_t op, input logic [ADDR_W-1:0] a, output int t);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		#1;
		while (req_ready !== 1'b1 && n < LIMIT) begin
			@(posedge mclk);
			#2;
			n++;
		end
		@(posedge mclk);
		#1;
		t = cyc;
		req_valid = 1'b0;
		req_op = OP_NOP;
		if (op < OP_SRE) check_val("op", ADDR_W'(pins.op), ADDR_W'(op));
		check_val("addr", pins.addr, a);
		@(posedge mclk);
		#1;
	endtask

	task automatic count_rises(input int cycles, output int r);
		logic last;
		r = 0;
		last = ck;
		repeat (cycles) begin
			@(posedge mclk);
			#1;
			if (ck === 1'b1 && last === 1'b0) r++;
			last = ck;
		end
	endtask

	// Start and length of the read gate or of the host strobe drive
	task automatic window(input int t, input logic rd, output int f, output int l);
		l = 0;
		f = 0;
		repeat (60) begin
			@(posedge mclk);
			#1;
			if ((rd ? rd_gate : ~dqs_oe_n) === 1'b1) begin
				if (l == 0) f = cyc - t;
				l++;
			end
		end
	endtask

	// ==================================================================
	// Scenarios
	task automatic test_reset();
		int n;
		n = 0;
		check_val("reset pins", ADDR_W'({pins.reset_n, pins.cke, req_ready, dqs_oe_n}),
			ADDR_W'(4'h1));
		rst = 1'b0;
		while (pins.cke !== 1'b1 && n < LIMIT) begin
			@(posedge mclk);
			#1;
			n++;
		end
		t0 = cyc;
		while (pins.op !== OP_ZQCL && n < LIMIT) begin
			@(posedge mclk);
			#1;
			n++;
		end
		t1 = cyc;
		check_cnt("cke to calib", (t1 - t0) / CKD, TXPR, TXPR + 1);
		issue(OP_ACT, ADDR_W'(17'h0_0000), t2);
		check_cnt("init calib", (t2 - t1) / CKD, T_ZQINIT_CK, T_ZQINIT_CK + 1);
		check_val("init done", ADDR_W'(init_done), ADDR_W'(1'b1));
		$display("test reset done");
	endtask

	task automatic test_calib();
		hdt_op_t zq [2] = '{OP_ZQCL, OP_ZQCS};
		int      g  [2] = '{T_ZQOPER_CK, T_ZQCS_CK};
		for (int i = 0; i < 2; i++) begin
			issue(zq[i], ADDR_W'(i), t0);
			issue(OP_ACT, ADDR_W'(17'h0_0000), t1);
			check_cnt("calib hold", (t1 - t0) / CKD, g[i], g[i] + 1);
		end
		$display("test calib done");
	endtask

	task automatic test_ops();
		hdt_op_t ops [5] = '{OP_MRS, OP_REF, OP_PRE, OP_ACT, OP_NOP};
		for (int i = 0; i < 5; i++) begin
			issue(ops[i], 17'h1_5a5a ^ ADDR_W'(i), t1);
			if (i > 0) check_cnt("back to back", (t1 - t0) / CKD, 1, 1);
			t0 = t1;
		end
		$display("test ops done");
	endtask

	task automatic test_self_refresh();
		int r;
		issue(OP_SRE, ADDR_W'(17'h0_0000), t0);
		check_val("sr entry", ADDR_W'({pins.cke, pins.op}), ADDR_W'({1'b0, OP_REF}));
		count_rises(40, r);
		check_cnt("clock after entry", r, T_CKSRE_MIN_CK, T_CKSRE_MIN_CK + 2);
		issue(OP_SRX, ADDR_W'(17'h0_0000), t1);
		issue(OP_MRS, ADDR_W'(17'h0_0000), t2);
		check_cnt("exit to mode write", (t2 - t1) / CKD, TXS4, TXS4 + 6);
		issue(OP_ACT, ADDR_W'(17'h0_0000), t2);
		check_cnt("exit to act", (t2 - t1) / CKD, TXS, TXS + 6);
		issue(OP_RD, ADDR_W'(17'h0_0000), t2);
		check_cnt("exit to read", (t2 - t1) / CKD, T_DLLK_CK, T_DLLK_CK + 6);
		window(t2, 1'b1, first, len);
		check_cnt("gate start", first, (RLAT - 1) * CKD, (RLAT - 1) * CKD + 2);
		check_cnt("gate length", len, (BLEN / 2 + 1) * CKD, (BLEN / 2 + 2) * CKD);
		check_val("strobe seen", ADDR_W'(rd_strobe_seen), ADDR_W'(1'b1));
		issue(OP_WR, ADDR_W'(17'h0_0000), t2);
		window(t2, 1'b0, first, len);
		check_cnt("write start", first, (WL - 1) * CKD, (WL - 1) * CKD + 2);
		check_cnt("write strobe", len, (BLEN / 2 + 1) * CKD + 1, (BLEN / 2 + 2) * CKD);
		$display("test self refresh done");
	endtask

	task automatic test_abort();
		par_en = 1'b1;
		issue(OP_SRE, ADDR_W'(17'h0_0000), t0);
		issue(OP_SRX_ABORT, ADDR_W'(17'h0_0000), t1);
		check_cnt("cke low", (t1 - t0) / CKD, TCKSR + PLAT, TCKSR + PLAT + 3);
		issue(OP_ACT, ADDR_W'(17'h0_0000), t2);
		check_cnt("abort to act", (t2 - t1) / CKD, TXS4, TXS4 + 6);
		par_en = 1'b0;
		$display("test abort done");
	endtask

	task automatic test_power_down();
		int r;
		issue(OP_PDE, ADDR_W'(17'h0_0000), t0);
		check_val("pd entry", ADDR_W'(pins.cke), ADDR_W'(1'b0));
		count_rises(20, r);
		check_cnt("clock in power down", r, 9, 10);
		issue(OP_PDX, ADDR_W'(17'h0_0000), t1);
		issue(OP_ACT, ADDR_W'(17'h0_0000), t2);
		check_val("pd exit", ADDR_W'(pins.cke), ADDR_W'(1'b1));
		$display("test power down done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		#1;
		test_reset();
		test_calib();
		test_ops();
		test_self_refresh();
		test_abort();
		test_power_down();
		check_val("device guard", ADDR_W'(viol), '0);
		conclude();
	end
endmodule
